// ### rtl/gswm_pkg.sv
// Constants, types and a helper function shared by the gauge status word mux.
package gswm_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int WORD_W   = 16;
  localparam int POS_W    = 12;
  localparam int ACC_W    = 15;
  localparam int VEL_W    = 8;
  localparam int HEAD_W   = 10;
  localparam int CNT_W    = 5;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DEV_MOVED_BIT = 4;
  localparam int DEV_RTZ_BIT   = 2;
  localparam int DEV_OT_BIT    = 0;
  localparam int DEV_SPARE5    = 5;
  localparam int DEV_SPARE3    = 3;
  localparam int DEV_SPARE1    = 1;
  localparam int ACC_RTZ_BIT   = 15;
  localparam int POS_ENB_BIT   = 15;
  localparam int POS_DIR_BIT   = 14;
  localparam int POS_HEADING_VS_TARGET_BIT  = 13;
  localparam int POS_CMD_BIT   = 12;
  localparam int CFG_ENB_BIT   = 0;
  localparam int CFG_SEL_HI    = 11;
  localparam int CFG_SEL_LO    = 8;

  // ==========================================================================
  // Reset values and fixed patterns
  // ==========================================================================
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
  localparam logic [ACC_W-1:0]  ACC_RST   = 15'h0000;
  localparam logic [VEL_W-1:0]  VEL_PAD   = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST   = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_LAST  = 5'h10;
  localparam logic [3:0]        TOP_IDX   = 4'hF;

  // ==========================================================================
  // Status word type
  // ==========================================================================
  typedef enum logic [1:0] {
    GSWM_SEL_DEV = 2'b00,
    GSWM_SEL_ACC = 2'b01,
    GSWM_SEL_POS = 2'b10,
    GSWM_SEL_VEL = 2'b11
  } gswm_sel_e;

  // Pointer state delivered by the motion logic on the system clock.
  typedef struct packed {
    logic             moving_away;
    logic             away_from_target;
    logic             off_target;
    logic [POS_W-1:0] location;
    logic [VEL_W-1:0] speed_index;
    logic             step_pulse;
  } gswm_motion_s;

  // Return-to-zero control and coil samples from the zero-sense path.
  typedef struct packed {
    logic             start;
    logic             stop;
    logic             sample_valid;
    logic [ACC_W-1:0] sample;
    logic [ACC_W-1:0] preload;
  } gswm_rtz_s;

  // Select field of the enable/configuration command to word type.
  function automatic gswm_sel_e gswm_decode_sel(input logic [3:0] sel);
    gswm_sel_e res;
    res = GSWM_SEL_DEV;
    if (!sel[3]) begin
      res = GSWM_SEL_DEV;
    end else if (!sel[2]) begin
      res = GSWM_SEL_ACC;
    end else if (!sel[1]) begin
      res = GSWM_SEL_POS;
    end else begin
      res = GSWM_SEL_VEL;
    end
    return res;
  endfunction

endpackage

// ### rtl/gswm_sync3.sv
// Three-stage synchroniser with agreement filter for an asynchronous level.
`timescale 1ns/1ps
module gswm_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Level in and filtered level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The output moves only when stages two and three agree, so a lone glitch is dropped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q     <= RST_VAL;
      s2_q     <= RST_VAL;
      s3_q     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end

endmodule // gswm_sync3

// ### rtl/gswm_zero_accum.sv
// Zero-sense integrator used during a return-to-zero sweep.
`timescale 1ns/1ps
module gswm_zero_accum
  import gswm_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Return-to-zero control and samples
  input  wire gswm_pkg::gswm_rtz_s       return_to_zero_active,
  // Result
  output logic [gswm_pkg::ACC_W-1:0]     integral_q,
  output logic                           zero_hit_q
);

  logic             run_q;
  logic [ACC_W-1:0] sum;
  logic             sign_after;

  // Two's complement wrap is intended; the top bit is the sign.
  assign sum        = integral_q + return_to_zero_active.sample;
  assign sign_after = sum[ACC_W-1];

  // Integrate only while running; afterwards the last result is kept for reading.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      integral_q <= ACC_RST;
      run_q      <= 1'b0;
      zero_hit_q <= 1'b0;
    end else begin
      zero_hit_q <= 1'b0;
      if (return_to_zero_active.start) begin
        integral_q <= return_to_zero_active.preload;
        run_q      <= 1'b1;
      end else if (return_to_zero_active.stop) begin
        run_q <= 1'b0;
      end else if (run_q && return_to_zero_active.sample_valid) begin
        integral_q <= sum;
        if (!sign_after) begin
          run_q      <= 1'b0;
          zero_hit_q <= 1'b1;
        end
      end
    end
  end

endmodule // gswm_zero_accum

// ### rtl/gswm_top.sv
// Status word selection, formatting and serial output for the gauge driver.
`timescale 1ns/1ps
// How it works
// - At chip select fall the chosen word is captured and shifted out MSB first.
// - The word type holds until a later valid configuration command or reset.
// - Select bit 11 low gives the device status word.
// - Bit 4 shows whether the pointer moved since the previous message.
// - Bit 2 is high from return-to-zero start until message after zero or off.
// - Overtemperature sets bit 0, disables the gauge, holds until re-enabled.
// - Device status bits 5, 3 and 1 carry nothing.
// - Select 10xx gives the zero-sense accumulator word.
// - Accumulator word bit 15 repeats the return-to-zero active flag.
// - Accumulator word bits 14..0 carry the 15-bit zero-sense integral.
// - Integral clears at reset and holds its last result after the sweep.
// - Integral is two's complement; its sign bit drives zero detection.
// - Select 110x gives the pointer position word.
// - Position bit 15 shows gauge enabled, bit 14 direction of motion.
// - Position bit 13 shows motion toward or away from the target.
// - Position bit 12 is low at the commanded position, high otherwise.
// - Position bits 11..0 hold pointer location sampled at chip select fall.
// - Select 111x gives the pointer velocity word.
// - Velocity bits 7..0 hold ramp step index sampled at chip select fall.
// - Velocity bits 15..8 carry nothing.
module gswm_top
  import gswm_pkg::*;
(
  // Clocks and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       sclk_link,
  // Serial link pins
  input  wire logic                       cs_n_pin,
  output logic                            so_out,
  output logic                            so_oe,
  // Command decoder, system clock
  input  wire logic                       msg_done,
  input  wire logic                       cfg_cmd_valid,
  input  wire logic [gswm_pkg::WORD_W-1:0] cfg_cmd_word,
  // Gauge events and state, system clock
  input  wire logic                       over_temp,
  input  wire logic [gswm_pkg::HEAD_W-1:0] dev_status_head,
  input  wire gswm_pkg::gswm_motion_s     motion,
  input  wire gswm_pkg::gswm_rtz_s        return_to_zero_active,
  // Control outputs to the gauge
  output logic                            gauge_enable,
  output logic                            rtz_active,
  output logic                            thermal_trip
);
  import gswm_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic              cs_n_sync;
  logic              cs_n_prev_q;
  logic              cs_fall;
  gswm_sel_e         sel_q;
  gswm_sel_e         sel_d;
  logic              gauge_on_q;
  logic              ot_q;
  logic              moved_q;
  logic              rtz_q;
  logic              zero_seen_q;
  logic [ACC_W-1:0]  integral;
  logic              zero_hit;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] dev_word;
  logic [WORD_W-1:0] acc_word;
  logic [WORD_W-1:0] pos_word;
  logic [WORD_W-1:0] vel_word;
  logic [WORD_W-1:0] word_mux;
  logic              reenable;
  logic              rtz_clear;
  logic              frame_rst_n;
  logic [CNT_W-1:0]  cnt_q;
  logic [3:0]        bit_idx;
  logic              so_q;
  logic              so_oe_q;

  // ==========================================================================
  // Chip select into the system domain
  // ==========================================================================
  gswm_sync3 #(
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (cs_n_pin),
    .sync_out (cs_n_sync)
  );

  // Falling edge of the filtered chip select starts a frame.
  assign cs_fall = cs_n_prev_q & ~cs_n_sync;

  // The old level resets high, so leaving reset never looks like a frame start.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_prev_q <= 1'b1;
    end else begin
      cs_n_prev_q <= cs_n_sync;
    end
  end

  // ==========================================================================
  // Word type selection
  // ==========================================================================
  // Apart from reset, only a valid configuration command may change the type; nothing else touches it.
  assign sel_d = cfg_cmd_valid ?
                 gswm_decode_sel(cfg_cmd_word[CFG_SEL_HI:CFG_SEL_LO]) : sel_q;

  // Reset brings back the device word, the same choice as at power-on.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= GSWM_SEL_DEV;
    end else begin
      sel_q <= sel_d;
    end
  end

  // ==========================================================================
  // Gauge enable and thermal trip
  // ==========================================================================
  // Only a command with the enable bit set may clear a trip.
  assign reenable = cfg_cmd_valid & cfg_cmd_word[CFG_ENB_BIT];

  // A trip in the same cycle as a re-enable wins, so the gauge stays safe.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gauge_on_q <= 1'b0;
      ot_q       <= 1'b0;
    end else begin
      if (over_temp) begin
        gauge_on_q <= 1'b0;
        ot_q       <= 1'b1;
      end else if (cfg_cmd_valid) begin
        gauge_on_q <= cfg_cmd_word[CFG_ENB_BIT];
        if (reenable) begin
          ot_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Movement since the previous message
  // ==========================================================================
  // A step in the cycle the message ends is kept for the next poll.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      moved_q <= 1'b0;
    end else if (motion.step_pulse) begin
      moved_q <= 1'b1;
    end else if (msg_done) begin
      moved_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Return-to-zero active flag
  // ==========================================================================
  // The integrator keeps its result after a sweep so that it can be read later.
  gswm_zero_accum u_accum (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .return_to_zero_active        (return_to_zero_active),
    .integral_q (integral),
    .zero_hit_q (zero_hit)
  );

  // The flag drops at the first message that ends after zero was found.
  assign rtz_clear = return_to_zero_active.stop | (msg_done & zero_seen_q);

  // A new start wins over any clear that falls in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rtz_q       <= 1'b0;
      zero_seen_q <= 1'b0;
    end else if (return_to_zero_active.start) begin
      rtz_q       <= 1'b1;
      zero_seen_q <= 1'b0;
    end else begin
      if (rtz_clear) begin
        rtz_q <= 1'b0;
      end
      if (zero_hit) begin
        zero_seen_q <= 1'b1;
      end else if (rtz_clear) begin
        zero_seen_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Word formatting and selection
  // ==========================================================================
  // Spare positions are tied low so every read is deterministic.
  assign dev_word = {dev_status_head, 1'b0, moved_q, 1'b0, rtz_q, 1'b0, ot_q};
  assign acc_word = {rtz_q, integral};
  assign pos_word = {gauge_on_q, motion.moving_away, motion.away_from_target,
                     motion.off_target, motion.location};
  assign vel_word = {VEL_PAD, motion.speed_index};
  assign word_mux = (sel_q == GSWM_SEL_ACC) ? acc_word :
                    (sel_q == GSWM_SEL_POS) ? pos_word :
                    (sel_q == GSWM_SEL_VEL) ? vel_word : dev_word;

  // Position and velocity fields are live; this snapshot is what freezes them.
  // Snapshot at frame start; it stays still for the whole frame so the link side may read it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= WORD_RST;
    end else if (cs_fall) begin
      word_q <= word_mux;
    end
  end

  // ==========================================================================
  // Link side shifter
  // ==========================================================================
  // A high chip select ends the frame without needing any link clock edge.
  assign frame_rst_n = rst_n & ~cs_n_pin;
  assign bit_idx     = TOP_IDX - cnt_q[3:0];

  // The snapshot settles well before the first link edge, so the link side reads a
  // quiet word; a master that clocks too soon after the fall gets stale bits.
  // Data leaves on the rising edge for the master to take on the falling edge.
  always_ff @(posedge sclk_link or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q   <= CNT_RST;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= 1'b1;
      if (cnt_q != CNT_LAST) begin
        so_q  <= word_q[bit_idx];
        cnt_q <= cnt_q + 5'h01;
      end else begin
        so_q <= 1'b0;
      end
    end
  end

  // Every output comes straight from its flip-flop.
  assign so_out       = so_q;
  assign so_oe        = so_oe_q;
  assign gauge_enable = gauge_on_q;
  assign rtz_active   = rtz_q;
  assign thermal_trip = ot_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Word type selection.
  a_sel_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_cmd_valid |=> $stable(sel_q)) else $error("word type changed without command");
  a_dev_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_cmd_valid && !cfg_cmd_word[11] |=> sel_q == GSWM_SEL_DEV)
    else $error("device word not selected");
  a_acc_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_cmd_valid && cfg_cmd_word[11:10] == 2'b10 |=> sel_q == GSWM_SEL_ACC)
    else $error("accumulator word not selected");
  a_pos_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_cmd_valid && cfg_cmd_word[11:8] == 4'hC |=> sel_q == GSWM_SEL_POS)
    else $error("position word not selected");
  a_vel_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_cmd_valid && cfg_cmd_word[11:9] == 3'h7 |=> sel_q == GSWM_SEL_VEL)
    else $error("velocity word not selected");

  // Status flags; each set wins over a clear in the same cycle.
  a_moved_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    motion.step_pulse |=> moved_q) else $error("movement flag lost");
  a_moved_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    moved_q && !msg_done |=> moved_q) else $error("movement flag dropped early");
  a_moved_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    msg_done && !motion.step_pulse |=> !moved_q) else $error("movement flag not cleared");
  a_trip_disable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    over_temp |=> ot_q && !gauge_on_q ##1 (ot_q || $past(reenable)))
    else $error("trip did not disable gauge");
  a_trip_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ot_q && !reenable |=> ot_q) else $error("trip flag dropped early");
  a_trip_gauge_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ot_q |-> !gauge_on_q) else $error("gauge on while tripped");
  a_rtz_life: assert property (@(posedge clk_sys) disable iff (!rst_n)
    return_to_zero_active.start ##1 !return_to_zero_active.stop && !msg_done |=> rtz_q) else $error("return flag dropped early");
  a_rtz_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    return_to_zero_active.start |=> rtz_q) else $error("return flag not set");
  a_rtz_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    return_to_zero_active.stop && !return_to_zero_active.start |=> !rtz_q) else $error("return flag not cleared by stop");
  a_dev_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q == GSWM_SEL_DEV |-> word_mux[DEV_MOVED_BIT] == moved_q
      && word_mux[DEV_RTZ_BIT] == rtz_q && word_mux[DEV_OT_BIT] == ot_q)
    else $error("device word flags misplaced");

  // Zero-sense integral.
  a_integral_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !return_to_zero_active.start && !return_to_zero_active.sample_valid |=> $stable(integral))
    else $error("integral moved while idle");
  a_zero_sign: assert property (@(posedge clk_sys) disable iff (!rst_n)
    zero_hit |-> !integral[ACC_W-1]) else $error("zero found with negative integral");

  // Word layouts, held against the package field positions.
  a_acc_layout: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q == GSWM_SEL_ACC |-> word_mux[ACC_RTZ_BIT] == rtz_q && word_mux[14:0] == integral)
    else $error("accumulator word misformatted");
  a_spare_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q == GSWM_SEL_DEV |-> !word_mux[DEV_SPARE5] && !word_mux[DEV_SPARE3]
                              && !word_mux[DEV_SPARE1]) else $error("spare bit set");
  a_vel_pad: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q == GSWM_SEL_VEL |-> word_mux[15:8] == VEL_PAD) else $error("velocity pad set");
  a_pos_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q == GSWM_SEL_POS |-> word_mux[POS_ENB_BIT] == gauge_on_q
      && word_mux[POS_DIR_BIT] == motion.moving_away
      && word_mux[POS_HEADING_VS_TARGET_BIT] == motion.away_from_target
      && word_mux[POS_CMD_BIT] == motion.off_target && word_mux[POS_W-1:0] == motion.location)
    else $error("position word misformatted");
  a_vel_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q == GSWM_SEL_VEL |-> word_mux[VEL_W-1:0] == motion.speed_index)
    else $error("velocity index misplaced");

  // Frame snapshot and serial order.
  a_word_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall |=> word_q == $past(word_mux) ##1 $stable(word_q) || $past(cs_fall))
    else $error("snapshot not taken at frame start");
  a_so_msb: assert property (@(posedge sclk_link) disable iff (!frame_rst_n)
    $rose(so_oe_q) |-> so_q == word_q[WORD_W-1] ##1 so_q == word_q[WORD_W-2])
    else $error("serial word not MSB first");

  // Main scenarios that the bench is meant to reach.
  c_dev_frame: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall && sel_q == GSWM_SEL_DEV && moved_q);
  c_acc_frame: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall && sel_q == GSWM_SEL_ACC && rtz_q);
  c_pos_frame: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall && sel_q == GSWM_SEL_POS);
  c_vel_frame: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cs_fall && sel_q == GSWM_SEL_VEL);
  c_trip_reenable: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ot_q ##[1:50] reenable);

endmodule // gswm_top

// ### bench/gswm_spi_master.sv
// SPI master model that clocks one 16-bit status word out of the gauge driver.
`timescale 1ns/1ps
module gswm_spi_master (
  // Link pins
  output logic      cs_n_pin,
  output logic      sclk_link,
  input  wire logic so_out,
  input  wire logic so_oe
);
  // Half period of the 125 ns link clock.
  localparam real HALF = 62.5;
  logic           oe_ok;

  // The clock is parked low between frames, so the link side only sees edges in a frame.
  initial begin
    cs_n_pin  = 1'b1;
    sclk_link = 1'b0;
    oe_ok     = 1'b1;
  end

  // One frame: data changes on the rising edge and is taken on the falling edge.
  task automatic xfer(output logic [15:0] w);
    int i;
    #7;  // Keeps the chip select edges off the system clock edges.
    cs_n_pin = 1'b0;
    #320;  // Leaves room for the snapshot, which lands up to 200 ns after the fall.
    for (i = 15; i >= 0; i--) begin
      sclk_link = 1'b1;
      #HALF;
      sclk_link = 1'b0;
      w[i] = so_out;
      if (so_oe !== 1'b1) begin
        oe_ok = 1'b0;
      end
      #HALF;
    end
    cs_n_pin = 1'b1;
    #1;
    if (so_oe !== 1'b0 || so_out !== 1'b0) begin
      oe_ok = 1'b0;
    end
    #300;  // Deselect time before the next frame.
  endtask
endmodule  // gswm_spi_master

// ### bench/tb.sv
// Self-checking testbench for the gauge status word mux.
`timescale 1ns/1ps
module tb;
  import gswm_pkg::*;
  logic              clk_sys, rst_n, sclk_link, cs_n_pin, so_out, so_oe;
  logic              msg_done, cfg_cmd_valid, over_temp;
  logic [WORD_W-1:0] cfg_cmd_word;
  logic [HEAD_W-1:0] dev_status_head;
  gswm_motion_s      motion;
  gswm_rtz_s         return_to_zero_active;
  logic              gauge_enable, rtz_active, thermal_trip;
  logic [WORD_W-1:0] w;
  int                miscompares, checks;
  // Rows of {command, expected word}; the pointer state stays fixed meanwhile.
  localparam logic [31:0] ROWS [9] = '{
    {16'h0001, 16'hA940}, {16'h0701, 16'hA940}, {16'h0801, 16'h0000},
    {16'h0B01, 16'h0000}, {16'h0C01, 16'hDABC}, {16'h0D01, 16'hDABC},
    {16'h0E01, 16'h005A}, {16'h0F01, 16'h005A}, {16'h0C00, 16'h5ABC}};

  // ==========================================================================
  // Device and far side
  // ==========================================================================
  gswm_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .cs_n_pin(cs_n_pin),
    .so_out(so_out), .so_oe(so_oe), .msg_done(msg_done), .cfg_cmd_valid(cfg_cmd_valid),
    .cfg_cmd_word(cfg_cmd_word), .over_temp(over_temp), .dev_status_head(dev_status_head),
    .motion(motion), .return_to_zero_active(return_to_zero_active), .gauge_enable(gauge_enable), .rtz_active(rtz_active),
    .thermal_trip(thermal_trip));
  gswm_spi_master master (
    .cs_n_pin(cs_n_pin), .sclk_link(sclk_link), .so_out(so_out), .so_oe(so_oe));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // The 25 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  // Control flags packed as {gauge on, return-to-zero, trip}.
  function automatic logic [15:0] flags();
    return {13'h0000, gauge_enable, rtz_active, thermal_trip};
  endfunction

  task automatic cfg(input logic [15:0] c);
    @(posedge clk_sys);
    cfg_cmd_word  <= c;
    cfg_cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cfg_cmd_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  // A whole message: the frame, then the decoder's end-of-message pulse.
  task automatic frame(output logic [15:0] r);
    master.xfer(r);
    @(posedge clk_sys);
    msg_done <= 1'b1;
    @(posedge clk_sys);
    msg_done <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic conclude();
    if (miscompares == 0 && checks > 0 && master.oe_ok === 1'b1) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang counts against the run, which ends through the same report.
  initial begin
    #2_000_000;
    miscompares++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n           = 1'b0;
    msg_done        = 1'b0;
    cfg_cmd_valid   = 1'b0;
    cfg_cmd_word    = 16'h0000;
    over_temp       = 1'b0;
    dev_status_head = 10'h2A5;
    return_to_zero_active             = '0;
    motion          = '{moving_away: 1'b1, away_from_target: 1'b0, off_target: 1'b1,
                        location: 12'hABC, speed_index: 8'h5A, step_pulse: 1'b0};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(flags(), 16'h0000);
    // Both ends of each select range, spare bits and the gauge-on bit.
    foreach (ROWS[i]) begin
      cfg(ROWS[i][31:16]);
      frame(w);
      check(w, ROWS[i][15:0]);
      check(flags(), {13'h0000, ROWS[i][16], 2'b00});
    end
    // Movement flag is set by a step and cleared by the next message.
    cfg(16'h0001);
    @(posedge clk_sys);
    motion.step_pulse <= 1'b1;
    @(posedge clk_sys);
    motion.step_pulse <= 1'b0;
    frame(w);
    check(w, 16'hA950);
    frame(w);
    check(w, 16'hA940);
    // Pointer state changes in mid-frame must not reach the word already taken.
    cfg(16'h0C01);
    fork
      master.xfer(w);
      begin
        #500;
        @(posedge clk_sys);
        motion.location         <= 12'h123;
        motion.away_from_target <= 1'b1;
        motion.off_target       <= 1'b0;
        motion.moving_away      <= 1'b0;
      end
    join
    check(w, 16'hDABC);
    frame(w);
    check(w, 16'hA123);
    // Return-to-zero: negative preload, one sample crosses zero, result held.
    cfg(16'h0801);
    @(posedge clk_sys);
    return_to_zero_active.preload <= 15'h7FFD;
    return_to_zero_active.start   <= 1'b1;
    @(posedge clk_sys);
    return_to_zero_active.start <= 1'b0;
    frame(w);
    check(w, 16'hFFFD);
    @(posedge clk_sys);
    return_to_zero_active.sample       <= 15'h0005;
    return_to_zero_active.sample_valid <= 1'b1;
    @(posedge clk_sys);
    return_to_zero_active.sample_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(flags(), 16'h0006);
    frame(w);
    check(w, 16'h8002);
    check(flags(), 16'h0004);
    @(posedge clk_sys);
    return_to_zero_active.sample_valid <= 1'b1;
    @(posedge clk_sys);
    return_to_zero_active.sample_valid <= 1'b0;
    frame(w);
    check(w, 16'h0002);
    // A sweep commanded off clears the flag without any message.
    @(posedge clk_sys);
    return_to_zero_active.start <= 1'b1;
    @(posedge clk_sys);
    return_to_zero_active.start <= 1'b0;
    @(posedge clk_sys);
    check(flags(), 16'h0006);
    return_to_zero_active.stop <= 1'b1;
    @(posedge clk_sys);
    return_to_zero_active.stop <= 1'b0;
    @(posedge clk_sys);
    check(flags(), 16'h0004);
    // Overtemperature: trip holds through messages and beats a same-cycle enable.
    cfg(16'h0001);
    @(posedge clk_sys);
    over_temp <= 1'b1;
    @(posedge clk_sys);
    over_temp <= 1'b0;
    @(posedge clk_sys);
    check(flags(), 16'h0001);
    frame(w);
    check(w, 16'hA941);
    frame(w);
    check(w, 16'hA941);
    @(posedge clk_sys);
    over_temp     <= 1'b1;
    cfg_cmd_valid <= 1'b1;
    @(posedge clk_sys);
    over_temp     <= 1'b0;
    cfg_cmd_valid <= 1'b0;
    @(posedge clk_sys);
    check(flags(), 16'h0001);
    cfg(16'h0001);  // Re-enable after the trip.
    check(flags(), 16'h0004);
    frame(w);
    check(w, 16'hA940);
    // A reset in mid-run brings the selection back to the device word.
    cfg(16'h0E01);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(flags(), 16'h0000);
    frame(w);
    check(w, 16'hA940);
    conclude();
  end
endmodule  // tb
